// *** pas_defines.svh ***
// Register offsets, field positions and reset values for the PWM auto-shutdown block
`ifndef PAS_DEFINES_SVH
`define PAS_DEFINES_SVH
`define PAS_OFF_DEADBAND  4'h0
`define PAS_OFF_SHUTDOWN  4'h1
`define PAS_OFF_IRQ_STAT  4'h2
`define PAS_OFF_IRQ_MASK  4'h3
`define PAS_RST_DEADBAND  8'h00
`define PAS_RST_SHUTDOWN  8'h00
`define PAS_RST_IRQ       2'h0
`define PAS_BIT_RESTART   7
`define PAS_BIT_STATUS    7
`define PAS_SRC_HI        6
`define PAS_SRC_LO        4
`define PAS_AC_HI         3
`define PAS_AC_LO         2
`define PAS_BD_HI         1
`define PAS_BD_LO         0
`define PAS_SRC_CMP1      0
`define PAS_SRC_CMP2      1
`define PAS_SRC_FAULT     2
`define PAS_IRQ_SHUT      0
`define PAS_IRQ_RESUME    1
`endif

// *** pas_pkg.sv ***
// Types shared by the PWM auto-shutdown block
package pas_pkg;
   typedef struct packed {
      logic [1:0] pair_one_shutdown_state;
      logic [1:0] pair_two_shutdown_state;
   } pas_states_type;
   typedef struct packed {
      logic out_a;
      logic out_b;
      logic out_c;
      logic out_d;
   } pas_pins_type;
   typedef enum logic [2:0] {
      PAS_RUN      = 3'b001,
      PAS_SHUT     = 3'b010,
      PAS_WAIT_PER = 3'b100
   } pas_state_type;
endpackage : pas_pkg

// *** pas_pwm_shutdown.sv ***
// PWM auto-shutdown, dead-band delay and register slave
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pas_defines.svh"
module pas_pwm_shutdown #(
   parameter int DELAY_W = 7
) (
   // Clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   // Avalon-MM slave
   input  wire logic [3:0]            avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [31:0]           avs_writedata_in,
   input  wire logic [3:0]            avs_byteenable_in,
   output logic [31:0]                avs_readdata_out,
   output logic                       avs_waitrequest_out,
   // Shutdown sources, from outside the clock domain
   input  wire logic                  comparator_one_in,
   input  wire logic                  comparator_two_in,
   input  wire logic                  fault_input_pin_in,
   // From the period timer and duty compare
   input  wire logic                  period_start_in,
   input  wire logic                  pwm_sched_a_in,
   input  wire logic                  pwm_sched_b_in,
   input  wire logic                  pwm_sched_c_in,
   input  wire logic                  pwm_sched_d_in,
   // Pin drive
   output pas_pkg::pas_pins_type      pin_level_out,
   output pas_pkg::pas_pins_type      pin_enable_out,
   // Interrupt
   output logic                       irq_out
);
   import pas_pkg::*;

   logic [7:0]          deadband_reg;
   logic [6:0]          shut_ctrl_reg;
   logic                status_reg;
   logic [1:0]          irq_stat_reg;
   logic [1:0]          irq_mask_reg;
   logic                ack_reg;
   logic [31:0]         rdata_reg;
   logic [2:0]          src_meta_reg;
   logic [2:0]          src_sync_reg;
   pas_state_type       state_reg;
   pas_pins_type        sched_reg;
   pas_pins_type        level_reg;
   logic [DELAY_W-1:0]  delay_cnt_a_reg;
   logic [DELAY_W-1:0]  delay_cnt_b_reg;

   logic                auto_restart_enable;
   logic [DELAY_W-1:0]  deadband_delay_count;
   logic [2:0]          shutdown_source_select;
   pas_states_type      states;
   logic                cause_sync;
   logic                cause_raw;
   logic                wr_shut;
   logic                wr_stat_one;
   logic                wr_stat_zero;
   logic                status_next;
   logic                hold_shut;
   logic                access;

   assign auto_restart_enable    = deadband_reg[`PAS_BIT_RESTART];
   assign deadband_delay_count   = deadband_reg[DELAY_W-1:0];
   assign shutdown_source_select = shut_ctrl_reg[`PAS_SRC_HI:`PAS_SRC_LO];
   // Pair one sits above pair two in both the register and the struct
   assign states                 = shut_ctrl_reg[`PAS_AC_HI:`PAS_BD_LO];

   // Synchronised cause for the status flag; bit select equals source bit
   assign cause_sync = |(src_sync_reg & shutdown_source_select);
   // Raw cause for the immediate pin override, bypassing the synchroniser
   assign cause_raw  = |({fault_input_pin_in, comparator_two_in, comparator_one_in}
                         & shutdown_source_select);

   // One wait state; read data is captured at the end of the wait cycle, writes take effect at the end of the acknowledge cycle
   assign access              = (avs_read_in | avs_write_in) & ~ack_reg;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
   assign wr_shut      = avs_write_in & ack_reg & (avs_address_in == `PAS_OFF_SHUTDOWN) & avs_byteenable_in[0];
   assign wr_stat_one  = wr_shut & avs_writedata_in[`PAS_BIT_STATUS];
   assign wr_stat_zero = wr_shut & ~avs_writedata_in[`PAS_BIT_STATUS] & ~cause_sync;

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         ack_reg <= 1'b0;
      else
         ack_reg <= access;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         src_meta_reg <= 3'h0;
         src_sync_reg <= 3'h0;
      end
      else
      begin
         src_meta_reg <= {fault_input_pin_in, comparator_two_in, comparator_one_in};
         src_sync_reg <= src_meta_reg;
      end
   end

   // Control register writes
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         deadband_reg  <= `PAS_RST_DEADBAND;
         shut_ctrl_reg <= 7'(`PAS_RST_SHUTDOWN);
         irq_mask_reg  <= `PAS_RST_IRQ;
      end
      else if (avs_write_in && ack_reg && avs_byteenable_in[0])
      begin
         if (avs_address_in == `PAS_OFF_DEADBAND)
            deadband_reg <= avs_writedata_in[7:0];
         if (avs_address_in == `PAS_OFF_SHUTDOWN)
            shut_ctrl_reg <= avs_writedata_in[6:0];
         if (avs_address_in == `PAS_OFF_IRQ_MASK)
            irq_mask_reg <= avs_writedata_in[1:0];
      end
   end

   // Status flag: hardware set wins over any clear
   always_comb
   begin
      status_next = status_reg;
      if (auto_restart_enable && !cause_sync)
         status_next = 1'b0;
      else if (wr_stat_zero)
         status_next = 1'b0;
      if (cause_sync || wr_stat_one)
         status_next = 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         status_reg <= 1'b0;
      else
         status_reg <= status_next;
   end

   // Period-aligned shutdown sequencing
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         state_reg <= PAS_RUN;
      else
      begin
         unique case (state_reg)
            PAS_RUN:
               if (status_next)
                  state_reg <= PAS_SHUT;
            PAS_SHUT:
               if (!status_next)
                  state_reg <= PAS_WAIT_PER;
            PAS_WAIT_PER:
               if (status_next)
                  state_reg <= PAS_SHUT;
               else if (period_start_in)
                  state_reg <= PAS_RUN;
            default:
               state_reg <= PAS_SHUT;
         endcase
      end
   end

   assign hold_shut = (state_reg != PAS_RUN) | cause_raw;

   // Dead-band delay on rising edges of pins A and B only; C and D follow their schedule inputs one clock later with no delay
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         sched_reg       <= '0;
         level_reg       <= '0;
         delay_cnt_a_reg <= '0;
         delay_cnt_b_reg <= '0;
      end
      else
      begin
         sched_reg <= '{pwm_sched_a_in, pwm_sched_b_in, pwm_sched_c_in, pwm_sched_d_in};
         level_reg.out_c <= pwm_sched_c_in;
         level_reg.out_d <= pwm_sched_d_in;
         if (!pwm_sched_a_in)
         begin
            level_reg.out_a <= 1'b0;
            delay_cnt_a_reg <= '0;
         end
         else if (!sched_reg.out_a)
         begin
            delay_cnt_a_reg <= deadband_delay_count;
            level_reg.out_a <= (deadband_delay_count == '0);
         end
         else if (delay_cnt_a_reg > 1)
            delay_cnt_a_reg <= delay_cnt_a_reg - 1'b1;
         else
         begin
            delay_cnt_a_reg <= '0;
            level_reg.out_a <= 1'b1;
         end
         if (!pwm_sched_b_in)
         begin
            level_reg.out_b <= 1'b0;
            delay_cnt_b_reg <= '0;
         end
         else if (!sched_reg.out_b)
         begin
            delay_cnt_b_reg <= deadband_delay_count;
            level_reg.out_b <= (deadband_delay_count == '0);
         end
         else if (delay_cnt_b_reg > 1)
            delay_cnt_b_reg <= delay_cnt_b_reg - 1'b1;
         else
         begin
            delay_cnt_b_reg <= '0;
            level_reg.out_b <= 1'b1;
         end
      end
   end

   // Pin drive; the override path is combinational so a fault acts without a clock edge
   always_comb
   begin
      pin_level_out  = level_reg;
      pin_enable_out = '1;
      if (hold_shut)
      begin
         pin_level_out.out_a  = states.pair_one_shutdown_state[0];
         pin_level_out.out_c  = states.pair_one_shutdown_state[0];
         pin_enable_out.out_a = ~states.pair_one_shutdown_state[1];
         pin_enable_out.out_c = ~states.pair_one_shutdown_state[1];
         pin_level_out.out_b  = states.pair_two_shutdown_state[0];
         pin_level_out.out_d  = states.pair_two_shutdown_state[0];
         pin_enable_out.out_b = ~states.pair_two_shutdown_state[1];
         pin_enable_out.out_d = ~states.pair_two_shutdown_state[1];
      end
   end

   // Interrupt events: entry to shutdown, and resume of normal output
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         irq_stat_reg <= `PAS_RST_IRQ;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == `PAS_IRQ_SHUT && status_next && !status_reg) ||
                (i == `PAS_IRQ_RESUME && state_reg == PAS_WAIT_PER && !status_next && period_start_in))
               irq_stat_reg[i] <= 1'b1;
            else if (avs_write_in && ack_reg && avs_byteenable_in[0] &&
                     avs_address_in == `PAS_OFF_IRQ_STAT && avs_writedata_in[i])
               irq_stat_reg[i] <= 1'b0;
         end
      end
   end

   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   // Read data, registered; unmapped addresses read zero
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         rdata_reg <= 32'h0;
      else if (access && avs_read_in)
      begin
         unique case (avs_address_in)
            `PAS_OFF_DEADBAND: rdata_reg <= {24'h0, deadband_reg};
            `PAS_OFF_SHUTDOWN: rdata_reg <= {24'h0, status_reg, shut_ctrl_reg};
            `PAS_OFF_IRQ_STAT: rdata_reg <= {30'h0, irq_stat_reg};
            `PAS_OFF_IRQ_MASK: rdata_reg <= {30'h0, irq_mask_reg};
            default:           rdata_reg <= 32'h0;
         endcase
      end
   end

   assign avs_readdata_out = rdata_reg;
endmodule : pas_pwm_shutdown
`default_nettype wire

// *** pas_chk.sv ***
// Assertions on the ports of the PWM auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module pas_chk (
   // Clock, reset and bus
   input wire logic                  clk_in,
   input wire logic                  rst_b_in,
   input wire logic [3:0]            avs_address_in,
   input wire logic                  avs_read_in,
   input wire logic                  avs_write_in,
   input wire logic [31:0]           avs_writedata_in,
   input wire logic [3:0]            avs_byteenable_in,
   input wire logic [31:0]           avs_readdata_out,
   input wire logic                  avs_waitrequest_out,
   // Sources, schedule and pins
   input wire logic                  comparator_one_in,
   input wire logic                  comparator_two_in,
   input wire logic                  fault_input_pin_in,
   input wire logic                  period_start_in,
   input wire logic                  pwm_sched_a_in,
   input wire pas_pkg::pas_pins_type pin_level_out,
   input wire pas_pkg::pas_pins_type pin_enable_out
);
   import pas_pkg::*;
   logic [6:0] ctl_reg;
   logic [6:0] dly_reg;
   logic [7:0] run_reg;
   logic       hit;
   logic       acc;
   // Shadows follow accepted writes so the pin checks know the live fields
   assign acc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   assign hit = |(ctl_reg[6:4] & {fault_input_pin_in, comparator_two_in, comparator_one_in});
   always_ff @(posedge clk_in)
      if (!rst_b_in) ctl_reg <= 7'h00;
      else if (acc && avs_address_in == 4'h1) ctl_reg <= avs_writedata_in[6:0];
   always_ff @(posedge clk_in)
      if (!rst_b_in) dly_reg <= 7'h00;
      else if (acc && avs_address_in == 4'h0) dly_reg <= avs_writedata_in[6:0];
   always_ff @(posedge clk_in)
      if (!pwm_sched_a_in) run_reg <= 8'h00;
      else if (run_reg != 8'hff) run_reg <= run_reg + 8'h01;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   property p_wait_first; $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out; endproperty
   property p_wait_done; $rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out; endproperty
   property p_read_pad; avs_read_in && !avs_waitrequest_out |->
      avs_readdata_out[31:8] == 24'h0 && (avs_address_in < 4'h4 || avs_readdata_out[7:0] == 8'h00); endproperty
   property p_pair_one; hit |-> pin_enable_out.out_a == !ctl_reg[3] && pin_enable_out.out_c == !ctl_reg[3]
      && (ctl_reg[3] || pin_level_out.out_a == ctl_reg[2]); endproperty
   property p_pair_two; hit |-> pin_enable_out.out_b == !ctl_reg[1] && pin_enable_out.out_d == !ctl_reg[1]
      && (ctl_reg[1] || pin_level_out.out_b == ctl_reg[0]); endproperty
   property p_db_rise; $rose(pin_level_out.out_a) && pin_enable_out.out_a && !hit |->
      run_reg >= {1'b0, dly_reg} && run_reg <= {1'b0, dly_reg} + 8'h02; endproperty
   property p_db_fall; $fell(pwm_sched_a_in) && !hit |-> ##[1:2] !pin_level_out.out_a; endproperty
   // Writes may legally retarget the state field, so they are left out
   property p_hold; !pin_enable_out.out_a && !period_start_in && !$past(period_start_in) && !avs_write_in
      |=> !pin_enable_out.out_a; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait cycle at request start");
   a_wait_done: assert property (p_wait_done) else $error("wait cycle too long");
   a_read_pad: assert property (p_read_pad) else $error("read data upper bits not zero");
   a_pair_one: assert property (p_pair_one) else $error("pair one shutdown drive wrong");
   a_pair_two: assert property (p_pair_two) else $error("pair two shutdown drive wrong");
   a_db_rise: assert property (p_db_rise) else $error("dead band delay wrong");
   a_db_fall: assert property (p_db_fall) else $error("falling edge delayed");
   a_hold: assert property (p_hold) else $error("pins left shutdown off period start");
   c_hit: cover property (hit);
   c_db: cover property ($rose(pin_level_out.out_a) && !hit);
   c_resume: cover property ($rose(pin_enable_out.out_a));
endmodule : pas_chk
`default_nettype wire

// *** pas_bridge_model.sv ***
// Switch driver model: pads with external pull-ups
`timescale 1ns/1ps
`default_nettype none
module pas_bridge_model #(
   parameter logic [3:0] PULL = 4'hf
) (
   input  wire pas_pkg::pas_pins_type pin_level_in,
   input  wire pas_pkg::pas_pins_type pin_enable_in,
   output logic [3:0]                 pad_out
);
   import pas_pkg::*;
   // Released pads show the pull, never the last driven level
   assign pad_out = (pin_level_in & pin_enable_in) | (PULL & ~pin_enable_in);
endmodule : pas_bridge_model
`default_nettype wire

// *** tb.sv ***
// Testbench for the PWM auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pas_pkg::*;
   logic clk_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic comparator_one_in = 1'b0, comparator_two_in = 1'b0, fault_input_pin_in = 1'b0;
   logic period_start_in = 1'b0, pwm_sched_a_in = 1'b0, pwm_sched_b_in = 1'b0, avs_waitrequest_out, irq_out;
   logic [3:0] avs_address_in = 4'h0, pad;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   pas_pins_type pin_level_out, pin_enable_out;
   int miscompares = 0;
   int n_compared = 0;
   always #20 clk_in = ~clk_in;
   pas_pwm_shutdown dut_u (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_byteenable_in(4'h1), .avs_readdata_out, .avs_waitrequest_out, .comparator_one_in, .comparator_two_in,
      .fault_input_pin_in, .period_start_in, .pwm_sched_a_in, .pwm_sched_b_in, .pwm_sched_c_in(1'b0),
      .pwm_sched_d_in(1'b0), .pin_level_out, .pin_enable_out, .irq_out);
   pas_bridge_model model_u (.pin_level_in(pin_level_out), .pin_enable_in(pin_enable_out), .pad_out(pad));
   task automatic report_and_stop();
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // One access; the slave decides how long it waits, up to 20 cycles before the test fails
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
      int i = 0;
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do
      begin
         @(posedge clk_in);
         i++;
      end
      while (avs_waitrequest_out !== 1'b0 && i < 20);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
      if (i >= 20)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task automatic tick();
      period_start_in <= 1'b1;
      @(posedge clk_in);
      period_start_in <= 1'b0;
      cyc(2);
   endtask : tick
   task automatic t_auto();
      rd(4'h1, 8'h00);
      rd(4'h9, 8'h00);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h80);
      wr(4'h3, 8'h03);
      wr(4'h1, 8'h41);
      fault_input_pin_in <= 1'b1;
      #1;
      chk({28'h0, pad}, 32'h5);
      cyc(4);
      rd(4'h1, 8'hc1);
      chk({31'h0, irq_out}, 32'h1);
      wr(4'h1, 8'h41);
      rd(4'h1, 8'hc1);
      fault_input_pin_in <= 1'b0;
      cyc(4);
      rd(4'h1, 8'h41);
      chk({28'h0, pad}, 32'h5);
      tick();
      chk({28'h0, pad}, 32'h0);
      rd(4'h2, 8'h03);
      wr(4'h2, 8'h03);
      chk({31'h0, irq_out}, 32'h0);
      $display("auto restart test done");
   endtask : t_auto
   task automatic t_manual();
      wr(4'h0, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h1, 8'h1f);
      comparator_one_in <= 1'b1;
      cyc(4);
      wr(4'h1, 8'h1f);
      rd(4'h1, 8'h9f);
      comparator_one_in <= 1'b0;
      cyc(4);
      rd(4'h1, 8'h9f);
      chk({31'h0, irq_out}, 32'h0);
      wr(4'h1, 8'h1f);
      rd(4'h1, 8'h1f);
      tick();
      chk({28'h0, pad}, 32'h0);
      wr(4'h1, 8'h9f);
      chk({28'h0, pad}, 32'hf);
      rd(4'h1, 8'h9f);
      wr(4'h1, 8'h1f);
      tick();
      $display("manual restart test done");
   endtask : t_manual
   task automatic t_sources();
      wr(4'h0, 8'h80);
      for (int s = 0; s < 8; s++)
      begin
         wr(4'h1, 8'(s * 16 + 8));
         for (int i = 0; i < 3; i++)
         begin
            {fault_input_pin_in, comparator_two_in, comparator_one_in} <= 3'(1 << i);
            #1;
            chk({31'h0, pad[3]}, {31'h0, s[i]});
            cyc(3);
            {fault_input_pin_in, comparator_two_in, comparator_one_in} <= 3'h0;
            cyc(4);
            tick();
         end
      end
      $display("source select test done");
   endtask : t_sources
   task automatic meas(input logic [6:0] dd, input int hold, output int n);
      wr(4'h0, {1'b1, dd});
      n = 0;
      pwm_sched_a_in <= 1'b1;
      pwm_sched_b_in <= 1'b1;
      do
      begin
         @(negedge clk_in);
         n++;
      end
      while (pin_level_out.out_a !== 1'b1 && n < hold);
      chk({31'h0, pin_level_out.out_b}, {31'h0, 32'(dd) < hold});
      @(posedge clk_in);
      pwm_sched_a_in <= 1'b0;
      pwm_sched_b_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk({31'h0, pin_level_out.out_a}, 32'h0);
      chk({31'h0, pin_level_out.out_b}, 32'h0);
      @(posedge clk_in);
   endtask : meas
   task automatic t_deadband();
      int n0, n2, n6, nx;
      meas(7'h00, 20, n0);
      meas(7'h02, 20, n2);
      meas(7'h06, 20, n6);
      meas(7'h06, 4, nx);
      chk(32'(n6 - n2), 32'h4);
      chk(32'(n0 < 3), 32'h1);
      chk(32'(nx), 32'h4);
      $display("dead band test done");
   endtask : t_deadband
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_auto();
      t_manual();
      t_sources();
      t_deadband();
      report_and_stop();
   end
endmodule : tb
bind pas_pwm_shutdown pas_chk chk_u (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
   .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .comparator_one_in,
   .comparator_two_in, .fault_input_pin_in, .period_start_in, .pwm_sched_a_in, .pin_level_out, .pin_enable_out);
`default_nettype wire
